/* dv/calc_user.sv */
// model of the user at the switches and the bidirectional pins
`timescale 1ns/100ps
module calc_user (
   input  wire logic       ref_clk,
   input  wire logic [7:0] uio_out,
   input  wire logic [7:0] uio_oe,
   output logic      [7:0] operand_in,
   output logic      [7:0] uio_in
);
   logic [3:0] op_r;
   logic       ent;
   initial begin
      operand_in = 8'h00;
      op_r       = 4'h0;
      ent        = 1'b0;
   end
   // wire level: device drives the flag bits, user the enter and op bits
   assign uio_in = (uio_oe & uio_out) | (~uio_oe & {3'h0, op_r, ent});
   task automatic push(input logic [3:0] op, input logic [7:0] x, input int hold);
      @(negedge ref_clk);
      operand_in = x;
      op_r       = op;
      repeat (3) @(negedge ref_clk);
      ent = 1'b1;
      repeat (hold) @(negedge ref_clk);
      ent = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
endmodule // calc_user

/* dv/testbench.sv */
// self-checking bench for the calculator alu
`timescale 1ns/100ps
module testbench;
   logic       ref_clk, rst_n;
   logic [7:0] operand_in, result_out, uio_in, uio_out, uio_oe, acc;
   logic [2:0] fl;
   int         n_errors, tests_run, cyc;
   calc_alu calc_alu_inst (.ref_clk(ref_clk), .rst_n(rst_n), .operand_in(operand_in),
      .result_out(result_out), .uio_in(uio_in), .uio_out(uio_out), .uio_oe(uio_oe));
   calc_user calc_user_inst (.ref_clk(ref_clk), .uio_out(uio_out), .uio_oe(uio_oe),
      .operand_in(operand_in), .uio_in(uio_in));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [10:0] f(input logic [3:0] o, input logic [7:0] a, x);
      logic [7:0] r;
      logic       v;
      v = 1'b0;
      case (o)
         4'h0: begin r = a + x; v = (a[7] == x[7]) && (r[7] != a[7]); end
         4'h1: begin r = a - x; v = (a[7] != x[7]) && (r[7] != a[7]); end
         4'h2: r = a | x;
         4'h3: r = a & x;
         4'h4: r = a ^ x;
         4'h5: begin r = x << 1; v = x[7]; end
         4'h6: r = x >> 1;
         4'h7: r = {x[7], x[7:1]};
         4'h8: begin r = -x; v = (x == 8'h80); end
         4'h9: r = ~x;
         4'hA: for (int i = 0; i < 8; i++) r[i] = x[7-i];
         4'hD: r = {7'h00, x < a};
         4'hE: r = {7'h00, x > a};
         4'hF: r = {7'h00, x == a};
         default: return {a, 1'b0, a[7], a == 8'h00};
      endcase
      return {r, v, r[7], r == 8'h00};
   endfunction
   task automatic op(input logic [3:0] o, input logic [7:0] x, input int hold);
      calc_user_inst.push(o, x, hold);
      {acc, fl} = f(o, acc, x);
      check("result", {result_out, uio_out[7:5]}, {acc, fl});
   endtask
   task automatic t_reset;
      @(negedge ref_clk);
      rst_n = 1'b0;
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      acc = 8'h00;
      fl  = 3'h0;
      check("reset", {result_out, uio_out[7:5]}, 11'h000);
      check("oe", {3'h0, uio_oe}, 11'h0E0);
   endtask
   task automatic t_ops;
      logic [7:0] x;
      for (int i = 0; i < 16; i++) begin
         x = 8'h3C ^ (i[7:0] * 8'h29);
         op(i[3:0], x, 3);
         check("low bits", {6'h00, uio_out[4:0]}, 11'h000);
      end
   endtask
   task automatic t_hold;
      op(4'h0, 8'h7F, 3);
      op(4'h0, 8'h01, 8);
      op(4'hF, 8'h80, 2);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         print_verdict;
      end
   end
   initial begin
      rst_n    = 1'b0;
      n_errors = 0;
      tests_run = 0;
      cyc      = 0;
      t_reset;
      t_ops;
      t_reset;
      t_hold;
      print_verdict;
   end
endmodule // testbench

/* hw/calc_alu.sv */
// top of the eight bit calculator alu
// Contract
// RULE_01 - operand arrives on input pins, result leaves on output pins, eight bits
// RULE_02 - bidirectional bit 0 is active high enter strobe from the user
// RULE_03 - bidirectional bits 4 to 1 carry the four bit operation select
// RULE_04 - device drives overflow, negative, zero flags on bidirectional bits 7 to 5
// RULE_05 - code 0 adds, code 1 subtracts operand from stored value
// RULE_06 - codes 2, 3, 4 give or, and, xor of both operands
// RULE_07 - codes 5, 6, 7 shift left, shift right logical, shift right arithmetic
// RULE_08 - codes 8, 9, A negate, invert, reverse bit order of operand
// RULE_09 - codes B and C are unused and change nothing; the code keeps the value but clears the overflow flag
// RULE_10 - codes D, E, F compare input with output: less, greater, equal
// RULE_11 - one operation per rising enter edge, result and flags updated together
// RULE_12 - reset clears stored result and all three flags
`timescale 1ns/100ps
`include "calc_alu_cfg.svh"
module calc_alu (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic [`CALC_W-1:0] operand_in,
   output logic      [`CALC_W-1:0] result_out,
   input  wire logic [`CALC_W-1:0] uio_in,
   output logic      [`CALC_W-1:0] uio_out,
   output logic      [`CALC_W-1:0] uio_oe
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [`CALC_W-1:0]          opd_s1_r, opd_s2_r;
   logic [`CALC_OP_W:0]         ctl_s1_r, ctl_s2_r;
   logic                        enter_d_r;
   logic                        fire;
   calc_pkg::calc_res_t         res;
   calc_pkg::calc_flags_t       flags_r;
   logic [`CALC_W-1:0]          acc_r;
   calc_pkg::calc_op_t          op_sel;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         opd_s1_r <= `CALC_ZERO;
         opd_s2_r <= `CALC_ZERO;
         ctl_s1_r <= '0;
         ctl_s2_r <= '0;
      end else begin
         opd_s1_r <= operand_in; //RULE_01
         opd_s2_r <= opd_s1_r;
         ctl_s1_r <= uio_in[`CALC_UIO_OP_HI:`CALC_UIO_ENTER]; //RULE_02 RULE_03
         ctl_s2_r <= ctl_s1_r;
      end
   end

   // ----------------------------------------
   // enter edge detect
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) enter_d_r <= 1'b0;
      else        enter_d_r <= ctl_s2_r[`CALC_UIO_ENTER];
   end
   assign fire = ctl_s2_r[`CALC_UIO_ENTER] & ~enter_d_r; //RULE_11

   assign op_sel = calc_pkg::calc_op_t'(ctl_s2_r[`CALC_UIO_OP_HI:`CALC_UIO_OP_LO]); //RULE_03

   calc_core calc_core_inst (
      .operand (opd_s2_r),
      .acc     (acc_r),
      .op      (op_sel),
      .res     (res)
   );

   // ----------------------------------------
   // result and flags
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         acc_r   <= `CALC_RES_RST; //RULE_12
         flags_r <= `CALC_FLG_RST; //RULE_12
      end else if (fire) begin
         acc_r   <= res.value; //RULE_11
         flags_r <= res.flags; //RULE_11
      end
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         result_out <= `CALC_RES_RST;
         uio_out    <= `CALC_ZERO;
         uio_oe     <= `CALC_ZERO;
      end else begin
         result_out <= fire ? res.value : acc_r; //RULE_01
         uio_out    <= {(fire ? res.flags : flags_r), {(`CALC_OP_W+1){1'b0}}}; //RULE_04
         uio_oe     <= `CALC_OE_FLAGS; //RULE_04
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   rst_clears_a: assert property (@(posedge ref_clk) //RULE_12
      !rst_n
      |=> result_out == `CALC_RES_RST && uio_out == `CALC_ZERO)
      else $error("reset not cleared");

   oe_reset_a: assert property (@(posedge ref_clk) //RULE_12
      !rst_n
      |=> uio_oe == `CALC_ZERO)
      else $error("pins driven in reset");

   hold_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_11
      !fire
      |=> $stable(acc_r) && $stable(flags_r))
      else $error("state changed without enter");

   one_shot_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_11
      fire
      |=> !fire)
      else $error("enter fired twice");

   out_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_01
      fire
      |=> result_out == acc_r)
      else $error("output not updated with result");

   flag_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_04
      fire
      |=> uio_out[`CALC_UIO_FLG_HI:`CALC_UIO_FLG_LO] == flags_r)
      else $error("flag pins wrong");

   zero_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_04
      fire
      |=> flags_r.zero == (acc_r == `CALC_ZERO))
      else $error("zero flag wrong");

   neg_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_04
      fire
      |=> flags_r.negative == acc_r[`CALC_MSB])
      else $error("negative flag wrong");

   add_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_05
      fire && op_sel == calc_pkg::CALC_ADD
      |=> acc_r == $past(acc_r) + $past(opd_s2_r))
      else $error("add wrong");

   add_ovf_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_05
      fire && op_sel == calc_pkg::CALC_ADD
      |=> flags_r.overflow == ($past(acc_r[`CALC_MSB]) == $past(opd_s2_r[`CALC_MSB]) &&
                               acc_r[`CALC_MSB] != $past(acc_r[`CALC_MSB])))
      else $error("add overflow wrong");

   sub_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_05
      fire && op_sel == calc_pkg::CALC_SUB
      |=> acc_r == $past(acc_r) - $past(opd_s2_r))
      else $error("subtract wrong");

   or_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_06
      fire && op_sel == calc_pkg::CALC_OR
      |=> acc_r == ($past(acc_r) | $past(opd_s2_r)))
      else $error("or wrong");

   and_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_06
      fire && op_sel == calc_pkg::CALC_AND
      |=> acc_r == ($past(acc_r) & $past(opd_s2_r)))
      else $error("and wrong");

   xor_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_06
      fire && op_sel == calc_pkg::CALC_XOR
      |=> acc_r == ($past(acc_r) ^ $past(opd_s2_r)))
      else $error("xor wrong");

   shl_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_07
      fire && op_sel == calc_pkg::CALC_SHL
      |=> acc_r == {$past(opd_s2_r[`CALC_MSB-1:0]), 1'b0})
      else $error("shift left wrong");

   shr_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_07
      fire && op_sel == calc_pkg::CALC_SHR
      |=> acc_r == {1'b0, $past(opd_s2_r[`CALC_MSB:1])})
      else $error("shift right wrong");

   asr_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_07
      fire && op_sel == calc_pkg::CALC_ASR
      |=> acc_r == {$past(opd_s2_r[`CALC_MSB]), $past(opd_s2_r[`CALC_MSB:1])})
      else $error("arithmetic shift wrong");

   neg_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_08
      fire && op_sel == calc_pkg::CALC_NEG
      |=> acc_r == `CALC_ZERO - $past(opd_s2_r))
      else $error("negate wrong");

   inv_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_08
      fire && op_sel == calc_pkg::CALC_INV
      |=> acc_r == ~$past(opd_s2_r))
      else $error("invert wrong");

   nop_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_09
      fire && op_sel == calc_pkg::CALC_NOP_B
      |=> $stable(acc_r))
      else $error("unused code changed value");

   nop_c_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_09
      fire && op_sel == calc_pkg::CALC_NOP_C
      |=> $stable(acc_r))
      else $error("unused code changed value");

   lt_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_10
      fire && op_sel == calc_pkg::CALC_LT
      |=> acc_r == (($past(opd_s2_r) < $past(acc_r)) ? `CALC_ONE : `CALC_ZERO))
      else $error("less compare wrong");

   gt_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_10
      fire && op_sel == calc_pkg::CALC_GT
      |=> acc_r == (($past(opd_s2_r) > $past(acc_r)) ? `CALC_ONE : `CALC_ZERO))
      else $error("greater compare wrong");

   eq_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_10
      fire && op_sel == calc_pkg::CALC_EQ
      |=> acc_r == (($past(opd_s2_r) == $past(acc_r)) ? `CALC_ONE : `CALC_ZERO))
      else $error("equal compare wrong");

   oe_fixed_a: assert property (@(posedge ref_clk) disable iff (!rst_n) //RULE_04
      1'b1
      |=> uio_oe == `CALC_OE_FLAGS)
      else $error("oe wrong");
endmodule // calc_alu

/* hw/calc_alu_cfg.svh */
// constants for the eight bit calculator alu
`ifndef CALC_ALU_CFG_SVH
`define CALC_ALU_CFG_SVH
`define CALC_W          8
`define CALC_OP_W       4
`define CALC_UIO_ENTER  0
`define CALC_UIO_OP_LO  1
`define CALC_UIO_OP_HI  4
`define CALC_UIO_FLG_LO 5
`define CALC_UIO_FLG_HI 7
`define CALC_OE_FLAGS   8'hE0
`define CALC_RES_RST    8'h00
`define CALC_FLG_RST    3'h0
`define CALC_ONE        8'h01
`define CALC_ZERO       8'h00
`define CALC_MSB        7
`endif

/* hw/calc_core.sv */
// combinational operation unit of the calculator
`timescale 1ns/100ps
`include "calc_alu_cfg.svh"
module calc_core (
   input  wire logic [`CALC_W-1:0] operand,
   input  wire logic [`CALC_W-1:0] acc,
   input  calc_pkg::calc_op_t      op,
   output calc_pkg::calc_res_t     res
);
   logic [`CALC_W:0]   wide;
   logic [`CALC_W-1:0] rev;
   logic               ovf;
   genvar              gi;
   generate
      for (gi = 0; gi < `CALC_W; gi++) begin : g_rev
         assign rev[gi] = operand[`CALC_MSB-gi];
      end
   endgenerate
   always_comb begin
      wide = {1'b0, `CALC_ZERO};
      ovf  = 1'b0;
      case (op)
         calc_pkg::CALC_ADD: begin
            wide = {1'b0, acc} + {1'b0, operand}; //RULE_05
            ovf  = (acc[`CALC_MSB] == operand[`CALC_MSB]) &&
                   (wide[`CALC_MSB] != acc[`CALC_MSB]);
         end
         calc_pkg::CALC_SUB: begin
            wide = {1'b0, acc} - {1'b0, operand}; //RULE_05
            ovf  = (acc[`CALC_MSB] != operand[`CALC_MSB]) &&
                   (wide[`CALC_MSB] != acc[`CALC_MSB]);
         end
         calc_pkg::CALC_OR:  wide = {1'b0, acc | operand}; //RULE_06
         calc_pkg::CALC_AND: wide = {1'b0, acc & operand}; //RULE_06
         calc_pkg::CALC_XOR: wide = {1'b0, acc ^ operand}; //RULE_06
         calc_pkg::CALC_SHL: begin
            wide = {1'b0, operand[`CALC_MSB-1:0], 1'b0}; //RULE_07
            ovf  = operand[`CALC_MSB];
         end
         calc_pkg::CALC_SHR: wide = {2'b00, operand[`CALC_MSB:1]}; //RULE_07
         calc_pkg::CALC_ASR: wide = {1'b0, operand[`CALC_MSB], operand[`CALC_MSB:1]}; //RULE_07
         calc_pkg::CALC_NEG: begin
            wide = {1'b0, (~operand) + `CALC_ONE}; //RULE_08
            ovf  = (operand == {1'b1, {(`CALC_W-1){1'b0}}});
         end
         calc_pkg::CALC_INV: wide = {1'b0, ~operand}; //RULE_08
         calc_pkg::CALC_REV: wide = {1'b0, rev}; //RULE_08
         calc_pkg::CALC_LT:  wide = {1'b0, (operand < acc) ? `CALC_ONE : `CALC_ZERO}; //RULE_10
         calc_pkg::CALC_GT:  wide = {1'b0, (operand > acc) ? `CALC_ONE : `CALC_ZERO}; //RULE_10
         calc_pkg::CALC_EQ:  wide = {1'b0, (operand == acc) ? `CALC_ONE : `CALC_ZERO}; //RULE_10
         default: wide = {1'b0, acc}; //RULE_09
      endcase
      res.value          = wide[`CALC_W-1:0];
      res.flags.overflow = ovf;
      res.flags.negative = wide[`CALC_MSB];
      res.flags.zero     = (wide[`CALC_W-1:0] == `CALC_ZERO);
   end
endmodule // calc_core

/* hw/calc_pkg.sv */
// types for the eight bit calculator alu
package calc_pkg;
   typedef enum logic [3:0] {
      CALC_ADD, CALC_SUB, CALC_OR, CALC_AND, CALC_XOR, CALC_SHL, CALC_SHR, CALC_ASR,
      CALC_NEG, CALC_INV, CALC_REV, CALC_NOP_B, CALC_NOP_C, CALC_LT, CALC_GT, CALC_EQ
   } calc_op_t;
   typedef struct packed {
      logic overflow;
      logic negative;
      logic zero;
   } calc_flags_t;
   typedef struct packed {
      logic [7:0]  value;
      calc_flags_t flags;
   } calc_res_t;
endpackage
